// file: inc/lpe_pkg.sv
// Constants and types shared by the logic primitive engine files.
`default_nettype none
package lpe_pkg;
	// Clock rate and the millisecond timer tick derived from it.
	localparam int CLK_HZ   = 40_000_000;
	localparam int TICK_US  = 1000;
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	// Run-cycle periods in milliseconds: 2, 10 and 20.
	localparam logic [4:0] RUN_FAST_MS = 5'h02;
	localparam logic [4:0] RUN_MID_MS  = 5'h0a;
	localparam logic [4:0] RUN_SLOW_MS = 5'h14;
	// Table sizes.
	localparam int NINST = 32;
	localparam int NANA  = 16;
	// Counter saturation value and the largest four-digit BCD value.
	localparam logic [15:0] CNT_SAT = 16'hffff;
	localparam logic [31:0] BCD_MAX = 32'h0000270f;
	// Register word addresses.
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_STAT   = 8'h01;
	localparam logic [7:0] A_NOW    = 8'h02;
	localparam logic [7:0] A_DIG_LO = 8'h04;
	localparam logic [7:0] A_DIG_HI = 8'h05;
	localparam logic [1:0] A_ANA    = 2'h1; // Top bits of 8'h10..8'h1f.
	localparam logic [1:0] A_PROG   = 2'h1; // Top bits of 8'h40..8'h7f.
	// Control register bits and reset value.
	localparam int   CTRL_RUN     = 0;
	localparam int   CTRL_RESTART = 1;
	localparam logic CTRL_RUN_RST = 1'b0;

	typedef enum logic [4:0] {
		OP_NOP, OP_XOR, OP_NOT, OP_CABLE, OP_FAN, OP_MUX, OP_ASEL,
		OP_PULSE, OP_TON, OP_TOFF, OP_DBI, OP_SCB, OP_ACAB, OP_CNT,
		OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_CMP, OP_LVL, OP_D2A,
		OP_BCD2A, OP_BIN2A, OP_A2BCD, OP_A2BIN, OP_PTRAIN, OP_EDGE
	} lpe_op_t;

	typedef enum logic [2:0] {
		CMP_GT, CMP_LT, CMP_EQ, CMP_NE, CMP_GE, CMP_LE
	} lpe_cmp_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} lpe_fsm_t;

	// One program word: low half at the even address, high half odd.
	typedef struct packed {
		logic [19:0] rsv_h;
		logic [5:0]  dst;
		logic [5:0]  c;
		logic [3:0]  rsv_l;
		logic [5:0]  b;
		logic [5:0]  a;
		logic        rsv_m;
		logic [3:0]  fan;
		lpe_cmp_t    cmp;
		logic [1:0]  prio;
		logic        mem;
		lpe_op_t     op;
	} lpe_inst_t;

	// Per-instance state: output, last first operand, time or count.
	typedef struct packed {
		logic        out;
		logic        prev;
		logic [31:0] t;
	} lpe_slot_t;

	// Register port request.
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} lpe_bus_t;
endpackage
`default_nettype wire

// file: rtl/lpe_tick.sv
// Millisecond time base and run-cycle scheduler of the logic engine.
`timescale 1ns/1ps
`default_nettype none
module lpe_tick #(
	parameter int TICK_CYC = lpe_pkg::TICK_CYC
) (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Time base.
	output logic [31:0]      now_ms,
	output logic [2:0]       due
);
	typedef struct packed {
		logic [31:0] div;
		logic [31:0] now;
		logic [4:0]  fast;
		logic [4:0]  mid;
		logic [4:0]  slow;
		logic [2:0]  due;
	} lpe_tick_t;

	lpe_tick_t q;
	lpe_tick_t d;
	logic      tick;

	// Step a phase counter and wrap it at its period.
	function automatic logic [4:0] step(logic [4:0] c, logic [4:0] per);
		return (c == per - 5'h01) ? 5'h00 : c + 5'h01;
	endfunction

	// One-cycle enable pulse every millisecond.
	assign tick = (q.div == 32'(TICK_CYC - 1));

	// Count milliseconds and flag each run cycle as it falls due.
	always_comb begin
		d = q;
		d.div = tick ? 32'h0 : q.div + 32'h1;
		d.due = 3'h0;
		if (tick) begin
			d.now = q.now + 32'h1;
			d.fast = step(q.fast, lpe_pkg::RUN_FAST_MS);
			d.mid = step(q.mid, lpe_pkg::RUN_MID_MS);
			d.slow = step(q.slow, lpe_pkg::RUN_SLOW_MS);
			d.due = {d.slow == 5'h00, d.mid == 5'h00, d.fast == 5'h00};
		end
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign now_ms = q.now;
	assign due = q.due;
endmodule
`default_nettype wire

// file: rtl/lpe_alu.sv
// Stateless gate, arithmetic, compare and conversion primitives.
`timescale 1ns/1ps
`default_nettype none
module lpe_alu (
	// Operation.
	input  wire lpe_pkg::lpe_op_t   op,
	input  wire lpe_pkg::lpe_cmp_t  cmp,
	// Operands.
	input  wire logic               a_d,
	input  wire logic               b_d,
	input  wire logic               c_d,
	input  wire logic [15:0]        w_in,
	input  wire logic signed [31:0] a_v,
	input  wire logic signed [31:0] b_v,
	input  wire logic signed [31:0] c_v,
	// Results.
	output logic                    y_d,
	output logic                    y_we,
	output logic signed [31:0]      y_v,
	output logic [15:0]             y_w
);
	logic signed [31:0] clip;

	// Evaluate the selected primitive; y_we marks an analog result.
	always_comb begin
		y_d = 1'b0;
		y_we = 1'b0;
		y_v = a_v;
		y_w = 16'h0000;
		clip = (a_v < 0) ? 32'sh0 : (a_v > $signed(lpe_pkg::BCD_MAX)) ?
			$signed(lpe_pkg::BCD_MAX) : a_v;
		unique case (op)
			lpe_pkg::OP_XOR: y_d = a_d ^ b_d;
			lpe_pkg::OP_NOT: y_d = !a_d;
			lpe_pkg::OP_CABLE, lpe_pkg::OP_FAN: y_d = a_d;
			lpe_pkg::OP_MUX: y_d = a_d ? c_d : b_d;
			lpe_pkg::OP_ASEL: begin
				y_we = 1'b1;
				y_v = a_d ? c_v : b_v;
			end
			lpe_pkg::OP_ACAB: y_we = 1'b1;
			lpe_pkg::OP_ADD: begin
				y_we = 1'b1;
				y_v = a_v + b_v;
			end
			lpe_pkg::OP_SUB: begin
				y_we = 1'b1;
				y_v = a_v - b_v;
			end
			lpe_pkg::OP_MUL: begin
				y_we = 1'b1;
				y_v = 32'(a_v * b_v);
			end
			lpe_pkg::OP_DIV: begin
				y_we = (b_v != 32'sh0);
				y_v = (b_v == 32'sh0) ? a_v : a_v / b_v;
			end
			lpe_pkg::OP_CMP: begin
				unique case (cmp)
					lpe_pkg::CMP_GT: y_d = a_v > b_v;
					lpe_pkg::CMP_LT: y_d = a_v < b_v;
					lpe_pkg::CMP_EQ: y_d = a_v == b_v;
					lpe_pkg::CMP_NE: y_d = a_v != b_v;
					lpe_pkg::CMP_GE: y_d = a_v >= b_v;
					lpe_pkg::CMP_LE: y_d = a_v <= b_v;
					default: y_d = 1'b0;
				endcase
			end
			lpe_pkg::OP_D2A: begin
				y_we = 1'b1;
				y_v = {31'h0, a_d};
			end
			lpe_pkg::OP_BCD2A: begin
				y_we = 1'b1;
				y_v = 32'(w_in[15:12]) * 32'sd1000 + 32'(w_in[11:8]) * 32'sd100
					+ 32'(w_in[7:4]) * 32'sd10 + 32'(w_in[3:0]);
			end
			lpe_pkg::OP_BIN2A: begin
				y_we = 1'b1;
				y_v = {16'h0000, w_in};
			end
			lpe_pkg::OP_A2BCD: y_w = {4'(clip / 1000), 4'(clip / 100 % 10),
				4'(clip / 10 % 10), 4'(clip % 10)};
			lpe_pkg::OP_A2BIN: y_w = a_v[15:0];
			default: y_d = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// file: rtl/lpe_engine.sv
// Cyclic engine that evaluates a program of configurable logic primitives.
`timescale 1ns/1ps
`default_nettype none
module lpe_engine #(
	parameter int TICK_CYC = lpe_pkg::TICK_CYC
) (
	// Clock and reset.
	input  wire logic            sys_clk,
	input  wire logic            rst,
	// Register port.
	input  wire lpe_pkg::lpe_bus_t bus,
	output logic [31:0]          bus_rdata,
	// Signals from and to the other functions of the device.
	input  wire logic [31:0]     sig_in,
	output logic [31:0]          sig_out
);
	localparam int PCW = $clog2(lpe_pkg::NINST);
	localparam logic [PCW-1:0] PC_LAST = PCW'(lpe_pkg::NINST - 1);

	typedef struct packed {
		lpe_pkg::lpe_fsm_t                         fsm;
		logic [PCW-1:0]                            pc;
		logic [2:0]                                due;
		logic [2:0]                                pend;
		logic                                      run;
		logic [31:0]                               sweeps;
		logic [63:0]                               dig;
		logic [lpe_pkg::NANA-1:0][31:0]            ana;
		lpe_pkg::lpe_inst_t [lpe_pkg::NINST-1:0]   prog;
		lpe_pkg::lpe_slot_t [lpe_pkg::NINST-1:0]   slot;
		logic [31:0]                               rdata;
	} lpe_eng_t;

	lpe_eng_t           q;
	lpe_eng_t           d;
	lpe_pkg::lpe_inst_t ins;
	lpe_pkg::lpe_slot_t sl;
	lpe_pkg::lpe_slot_t sn;
	logic [31:0]        now_ms;
	logic [2:0]         due_now;
	logic               ex;
	logic               a_d;
	logic               b_d;
	logic               c_d;
	logic [15:0]        w_in;
	logic [31:0]        a_v;
	logic [31:0]        b_v;
	logic [31:0]        c_v;
	logic [31:0]        el;
	logic               y_d;
	logic               y_we;
	logic [31:0]        y_v;
	logic [15:0]        y_w;
	logic [63:0]        mask;
	logic [63:0]        wval;
	logic               restart;

	// Mask of n digital lanes starting at lane at.
	function automatic logic [63:0] lanes(logic [4:0] n, logic [5:0] at);
		return ((64'h1 << n) - 64'h1) << at;
	endfunction

	// Primitives that may keep their state across a shutdown.
	function automatic logic memo(lpe_pkg::lpe_op_t op);
		return op inside {lpe_pkg::OP_PULSE, lpe_pkg::OP_TON,
			lpe_pkg::OP_TOFF, lpe_pkg::OP_DBI, lpe_pkg::OP_SCB,
			lpe_pkg::OP_CNT, lpe_pkg::OP_LVL, lpe_pkg::OP_PTRAIN};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Time base and stateless primitives.

	lpe_tick #(
		.TICK_CYC (TICK_CYC)
	) u_tick (
		.sys_clk (sys_clk),
		.rst     (rst),
		.now_ms  (now_ms),
		.due     (due_now)
	);

	lpe_alu u_alu (
		.op   (ins.op),
		.cmp  (ins.cmp),
		.a_d  (a_d),
		.b_d  (b_d),
		.c_d  (c_d),
		.w_in (w_in),
		.a_v  (a_v),
		.b_v  (b_v),
		.c_v  (c_v),
		.y_d  (y_d),
		.y_we (y_we),
		.y_v  (y_v),
		.y_w  (y_w)
	);

	////////////////////////////////////////////////////////////////////////
	// Operand fetch for the instance under the program counter.

	// An instance runs only in a sweep of its own priority class.
	assign ins = q.prog[q.pc];
	assign sl = q.slot[q.pc];
	assign ex = (q.fsm == lpe_pkg::ST_RUN) && (ins.prio != 2'h0)
		&& q.due[ins.prio - 2'h1];
	assign a_d = q.dig[ins.a];
	assign b_d = q.dig[ins.b];
	assign c_d = q.dig[ins.c];
	assign w_in = 16'(q.dig >> ins.a);
	assign a_v = q.ana[ins.a[3:0]];
	assign b_v = q.ana[ins.b[3:0]];
	assign c_v = q.ana[ins.c[3:0]];
	// Durations are whole milliseconds, unsigned, up to 2^32 - 1.
	assign el = now_ms - sl.t;
	assign restart = bus.wr && (bus.addr == lpe_pkg::A_CTRL)
		&& bus.wdata[lpe_pkg::CTRL_RESTART];

	////////////////////////////////////////////////////////////////////////
	// Next state.

	// Sweep control, instance evaluation, result write-back and registers.
	always_comb begin
		d = q;
		sn = sl;
		mask = 64'h0;
		wval = 64'h0;
		d.rdata = 32'h0;
		d.pend = q.pend | (due_now & {3{q.run}});
		unique case (q.fsm)
			lpe_pkg::ST_IDLE: begin
				if (q.pend != 3'h0) begin
					d.fsm = lpe_pkg::ST_RUN;
					d.due = q.pend;
					d.pend = due_now & {3{q.run}};
					d.pc = '0;
				end
			end
			lpe_pkg::ST_RUN: begin
				d.pc = q.pc + PCW'(1);
				if (q.pc == PC_LAST) begin
					d.fsm = lpe_pkg::ST_IDLE;
					d.sweeps = q.sweeps + 32'h1;
				end
			end
		endcase
		if (ex) begin
			sn.prev = a_d;
			unique case (ins.op)
				lpe_pkg::OP_PULSE: begin
					if (a_d && !sl.prev) begin
						sn.out = 1'b1;
						sn.t = now_ms;
					end else if (sl.out && el >= b_v) begin
						sn.out = 1'b0;
					end
				end
				lpe_pkg::OP_TON: begin
					if (!a_d) begin
						sn.out = 1'b0;
					end else if (!sl.prev) begin
						sn.t = now_ms;
						sn.out = (b_v == 32'h0);
					end else begin
						sn.out = (el >= b_v);
					end
				end
				lpe_pkg::OP_TOFF: begin
					if (a_d) begin
						sn.out = 1'b1;
						sn.t = now_ms;
					end else begin
						sn.out = sl.out && (el < b_v);
					end
				end
				lpe_pkg::OP_DBI: begin
					if (a_d && !sl.prev) begin
						sn.out = b_d;
					end
				end
				lpe_pkg::OP_SCB: begin
					if (a_d) begin
						sn.out = 1'b0;
					end else if (b_d) begin
						sn.out = c_d;
					end
				end
				lpe_pkg::OP_CNT: begin
					if (b_d) begin
						sn.t = 32'h0;
					end else if (a_d && !sl.prev
						&& sl.t[15:0] != lpe_pkg::CNT_SAT) begin
						sn.t = sl.t + 32'h1;
					end
				end
				lpe_pkg::OP_LVL: begin
					if ($signed(a_v) > $signed(c_v)) begin
						sn.out = 1'b1;
					end else if ($signed(a_v) < $signed(b_v)) begin
						sn.out = 1'b0;
					end
				end
				lpe_pkg::OP_PTRAIN: begin
					if (!a_d) begin
						sn.out = 1'b0;
					end else if (!sl.prev || (!sl.out && el >= c_v)) begin
						sn.out = 1'b1;
						sn.t = now_ms;
					end else if (sl.out && el >= b_v) begin
						sn.out = 1'b0;
						sn.t = now_ms;
					end
				end
				lpe_pkg::OP_EDGE: sn.out = a_d && !sl.prev;
				default: sn.out = y_d;
			endcase
			d.slot[q.pc] = sn;
			// Digital write-back: one lane, a fan-out group or 16 lanes.
			unique case (ins.op)
				lpe_pkg::OP_FAN: begin
					mask = lanes({1'b0, ins.fan} + 5'h01, ins.dst);
					wval = {64{a_d}};
				end
				lpe_pkg::OP_A2BCD, lpe_pkg::OP_A2BIN: begin
					mask = lanes(5'h10, ins.dst);
					wval = {48'h0, y_w} << ins.dst;
				end
				lpe_pkg::OP_ASEL, lpe_pkg::OP_ACAB, lpe_pkg::OP_CNT,
				lpe_pkg::OP_ADD, lpe_pkg::OP_SUB, lpe_pkg::OP_MUL,
				lpe_pkg::OP_DIV, lpe_pkg::OP_D2A, lpe_pkg::OP_BCD2A,
				lpe_pkg::OP_BIN2A, lpe_pkg::OP_NOP: mask = 64'h0;
				default: begin
					mask = lanes(5'h01, ins.dst);
					wval = {64{sn.out}};
				end
			endcase
			d.dig = (q.dig & ~mask) | (wval & mask);
			// Analog write-back; a zero divisor leaves the old value.
			if (ins.op == lpe_pkg::OP_CNT) begin
				d.ana[ins.dst[3:0]] = {16'h0000, sn.t[15:0]};
			end else if (y_we) begin
				d.ana[ins.dst[3:0]] = y_v;
			end
		end
		// Input lanes always follow the other functions.
		d.dig[31:0] = sig_in;
		// Register writes; a write to an analog slot overrides the engine.
		if (bus.wr) begin
			if (bus.addr == lpe_pkg::A_CTRL) begin
				d.run = bus.wdata[lpe_pkg::CTRL_RUN];
			end else if (bus.addr[7:4] == {2'h0, lpe_pkg::A_ANA}) begin
				d.ana[bus.addr[3:0]] = bus.wdata;
			end else if (bus.addr[7:6] == lpe_pkg::A_PROG) begin
				if (bus.addr[0]) begin
					d.prog[bus.addr[5:1]][63:32] = bus.wdata;
				end else begin
					d.prog[bus.addr[5:1]][31:0] = bus.wdata;
				end
			end
		end
		// Restart after shutdown: drop state unless it may be kept.
		if (restart) begin
			for (int i = 0; i < lpe_pkg::NINST; i++) begin
				if (!(q.prog[i].mem && memo(q.prog[i].op))) begin
					d.slot[i] = '0;
				end
			end
			d.fsm = lpe_pkg::ST_IDLE;
			d.pend = 3'h0;
		end
		// Read data stand in the cycle after the strobe only.
		if (bus.rd) begin
			if (bus.addr == lpe_pkg::A_CTRL) begin
				d.rdata = {31'h0, q.run};
			end else if (bus.addr == lpe_pkg::A_STAT) begin
				d.rdata = {q.sweeps[23:0], 1'b0, q.pend, q.due,
					q.fsm == lpe_pkg::ST_RUN};
			end else if (bus.addr == lpe_pkg::A_NOW) begin
				d.rdata = now_ms;
			end else if (bus.addr == lpe_pkg::A_DIG_LO) begin
				d.rdata = q.dig[31:0];
			end else if (bus.addr == lpe_pkg::A_DIG_HI) begin
				d.rdata = q.dig[63:32];
			end else if (bus.addr[7:4] == {2'h0, lpe_pkg::A_ANA}) begin
				d.rdata = q.ana[bus.addr[3:0]];
			end else if (bus.addr[7:6] == lpe_pkg::A_PROG) begin
				d.rdata = bus.addr[0] ? q.prog[bus.addr[5:1]][63:32]
					: q.prog[bus.addr[5:1]][31:0];
			end
		end
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
			q.fsm <= lpe_pkg::ST_IDLE;
			q.run <= lpe_pkg::CTRL_RUN_RST;
		end else begin
			q <= d;
		end
	end

	assign bus_rdata = q.rdata;
	assign sig_out = q.dig[63:32];

	////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_xor;
		@(posedge sys_clk) disable iff (rst)
		ex && ins.op == lpe_pkg::OP_XOR && ins.dst[5] |=>
			q.dig[$past(ins.dst)] == ($past(a_d) ^ $past(b_d));
	endproperty
	a_xor: assert property (p_xor)
		else $error("xor output differs from its inputs");

	property p_not;
		@(posedge sys_clk) disable iff (rst)
		ex && ins.op == lpe_pkg::OP_NOT && ins.dst[5] |=>
			q.dig[$past(ins.dst)] != $past(a_d);
	endproperty
	a_not: assert property (p_not)
		else $error("inverter output equals its input");

	property p_mux;
		@(posedge sys_clk) disable iff (rst)
		ex && ins.op == lpe_pkg::OP_MUX && ins.dst[5] && a_d |=>
			q.dig[$past(ins.dst)] == $past(c_d);
	endproperty
	a_mux: assert property (p_mux)
		else $error("multiplexer passed the wrong input");

	property p_cnt_clr;
		@(posedge sys_clk) disable iff (rst)
		ex && ins.op == lpe_pkg::OP_CNT && b_d && !restart |=>
			q.slot[$past(q.pc)].t == 32'h0;
	endproperty
	a_cnt_clr: assert property (p_cnt_clr)
		else $error("counter not cleared by its reset operand");

	property p_cnt_sat;
		@(posedge sys_clk) disable iff (rst)
		ex && ins.op == lpe_pkg::OP_CNT && !b_d && !restart
			&& sl.t[15:0] == lpe_pkg::CNT_SAT |=>
			q.slot[$past(q.pc)].t[15:0] == lpe_pkg::CNT_SAT;
	endproperty
	a_cnt_sat: assert property (p_cnt_sat)
		else $error("counter moved past saturation");

	property p_div0;
		@(posedge sys_clk) disable iff (rst)
		ex && ins.op == lpe_pkg::OP_DIV && b_v == 32'h0 && !bus.wr |=>
			$stable(q.ana);
	endproperty
	a_div0: assert property (p_div0)
		else $error("division by zero changed an analog slot");

	property p_lvl;
		@(posedge sys_clk) disable iff (rst)
		ex && ins.op == lpe_pkg::OP_LVL && !restart
			&& $signed(a_v) > $signed(c_v) |=> q.slot[$past(q.pc)].out;
	endproperty
	a_lvl: assert property (p_lvl)
		else $error("level comparator not set above maximum");

	property p_edge;
		@(posedge sys_clk) disable iff (rst)
		ex && ins.op == lpe_pkg::OP_EDGE && ins.dst[5] && sl.prev |=>
			!q.dig[$past(ins.dst)];
	endproperty
	a_edge: assert property (p_edge)
		else $error("edge detector fired without a rising input");

	property p_ton_low;
		@(posedge sys_clk) disable iff (rst)
		ex && ins.op == lpe_pkg::OP_TON && ins.dst[5] && !a_d |=>
			!q.dig[$past(ins.dst)];
	endproperty
	a_ton_low: assert property (p_ton_low)
		else $error("on-delay output high with its input low");
endmodule
`default_nettype wire

// file: dv/tb_lpe_engine.sv
// Self-checking testbench of the logic primitive engine.
`timescale 1ns/1ps
`default_nettype none
module tb_lpe_engine;
	localparam int TICK = 4;
	logic              sys_clk;
	logic              rst;
	lpe_pkg::lpe_bus_t bus;
	logic [31:0]       bus_rdata;
	logic [31:0]       sig_in;
	logic [31:0]       sig_out;
	logic [31:0]       v;
	logic [3:0]        m;
	int                errors;
	int                comparisons;
	int                edges = 0;
	int                n0;
	logic              e47 = 1'b0;

	// Counts rising edges on output lane 47.
	always @(posedge sys_clk) begin
		e47 <= sig_out[15];
		if (sig_out[15] && !e47)
			edges <= edges + 1;
	end

	// Engine with a short millisecond tick.
	lpe_engine #(.TICK_CYC(TICK)) uut (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.bus      (bus),
		.bus_rdata(bus_rdata),
		.sig_in   (sig_in),
		.sig_out  (sig_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Compares one result word and counts it.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// One write cycle on the register port.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask

	// One read cycle; the data stand only in the following cycle.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		@(negedge sys_clk);
		d = bus_rdata;
	endtask

	// Reads a register and compares it.
	task automatic rda(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(d, e);
	endtask

	// Compares one output lane, numbered as a program destination.
	task automatic cd(input int k, input logic e);
		chk({31'h0, sig_out[k-32]}, {31'h0, e});
	endtask

	// Writes both halves of one program word in the 2 ms class.
	task automatic pg(input int i, input lpe_pkg::lpe_op_t op,
		input int a, input int b, input int c,
		input int d, input logic [2:0] cm = 3'h0,
		input logic [3:0] f = 4'h0);
		wr({2'h1, 5'(i), 1'b0},
			{4'h0, 6'(b), 6'(a), 1'b0, f, cm, 2'h1, 1'b0, op});
		wr({2'h1, 5'(i), 1'b1}, {20'h0, 6'(d), 6'(c)});
	endtask

	// Waits until two more sweeps have ended, the first possibly partial, bounded.
	task automatic settle;
		logic [31:0] s0;
		rd(8'h01, s0);
		for (int i = 0; i < 300; i++) begin
			rd(8'h01, v);
			if (v[31:8] - s0[31:8] >= 24'h2)
				break;
		end
	endtask

	// Drives the input lanes and lets the program see them.
	task automatic drive(input logic [31:0] x);
		@(posedge sys_clk);
		sig_in <= x;
		settle;
	endtask

	// Rewrites the arithmetic instance and checks its result.
	task automatic ar(input lpe_pkg::lpe_op_t op, input logic [31:0] e);
		pg(10, op, 1, 2, 0, 3);
		settle;
		rda(8'h13, e);
	endtask

	// Sets the level comparator input and checks its output.
	task automatic lv(input logic [31:0] x, input logic e);
		wr(8'h11, x);
		settle;
		cd(43, e);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Clock of 25 ns period.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (30000) @(posedge sys_clk);
		errors++;
		finish_test;
	end

	// Main sequence.
	initial begin
		rst = 1'b1;
		bus = '0;
		sig_in = '0;
		errors = 0;
		comparisons = 0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		chk(sig_out, 32'h0);
		chk(bus_rdata, 32'h0);
		rda(8'h00, 32'h0);
		rda(8'h03, 32'h0);
		wr(8'h11, 32'h7);
		wr(8'h12, 32'h5);
		wr(8'h14, 32'h0);
		wr(8'h15, 32'h55);
		wr(8'h16, 32'ha);
		wr(8'h17, 32'h14);
		wr(8'h18, 32'h64);
		pg(0, lpe_pkg::OP_XOR, 0, 1, 0, 32);
		pg(1, lpe_pkg::OP_NOT, 2, 0, 0, 33);
		pg(2, lpe_pkg::OP_CABLE, 3, 0, 0, 34);
		pg(3, lpe_pkg::OP_FAN, 4, 0, 0, 35, 3'h0, 4'h2);
		pg(4, lpe_pkg::OP_MUX, 5, 6, 7, 38);
		pg(5, lpe_pkg::OP_ASEL, 5, 1, 2, 9);
		pg(6, lpe_pkg::OP_D2A, 3, 0, 0, 10);
		pg(7, lpe_pkg::OP_DBI, 9, 10, 0, 40);
		pg(8, lpe_pkg::OP_SCB, 11, 12, 13, 41);
		pg(9, lpe_pkg::OP_CNT, 14, 15, 0, 0);
		pg(11, lpe_pkg::OP_DIV, 1, 4, 0, 5);
		pg(13, lpe_pkg::OP_LVL, 1, 6, 7, 43);
		pg(14, lpe_pkg::OP_TON, 16, 8, 0, 44);
		pg(15, lpe_pkg::OP_TOFF, 16, 8, 0, 45);
		pg(16, lpe_pkg::OP_PULSE, 16, 8, 0, 46);
		wr(8'h00, 32'h1);
		// Gates, cables, fan-out, selectors and conversion over all inputs.
		for (int k = 0; k < 16; k++) begin
			m = k[3:0];
			drive({24'h0, m, m});
			chk({25'h0, sig_out[6:0]}, {25'h0, (m[1] ? m[3] : m[2]),
				{3{m[0]}}, m[3], ~m[2], m[0] ^ m[1]});
			rda(8'h19, m[1] ? 32'h5 : 32'h7);
			rda(8'h1a, {31'h0, m[3]});
		end
		// Data bistable: captures only on a rising clock operand.
		drive(32'h400);
		cd(40, 1'b0);
		drive(32'h600);
		cd(40, 1'b1);
		drive(32'h200);
		cd(40, 1'b1);
		drive(32'h0);
		drive(32'h200);
		cd(40, 1'b0);
		// Set-clear bistable: follows while set, clear wins.
		drive(32'h3000);
		cd(41, 1'b1);
		drive(32'h0);
		cd(41, 1'b1);
		drive(32'h800);
		cd(41, 1'b0);
		drive(32'h3800);
		cd(41, 1'b0);
		// Counter: three rising clocks, then its reset operand.
		repeat (3) begin
			drive(32'h4000);
			drive(32'h0);
		end
		rda(8'h10, 32'h3);
		drive(32'h8000);
		rda(8'h10, 32'h0);
		drive(32'h0);
		// Arithmetic on 7 and 5, and division by zero holding its result.
		ar(lpe_pkg::OP_ADD, 32'hc);
		ar(lpe_pkg::OP_SUB, 32'h2);
		ar(lpe_pkg::OP_MUL, 32'h23);
		ar(lpe_pkg::OP_DIV, 32'h1);
		rda(8'h15, 32'h55);
		// Every comparison code on 7 against 5.
		for (int c = 0; c < 6; c++) begin
			pg(12, lpe_pkg::OP_CMP, 1, 2, 0, 42, c[2:0]);
			settle;
			cd(42, 1'(6'b011001 >> c));
		end
		// Level comparator with references 10 and 20.
		lv(32'h19, 1'b1);
		lv(32'hf, 1'b1);
		lv(32'h5, 1'b0);
		lv(32'hf, 1'b0);
		// Timers of 100 ms, all on the same input lane.
		drive(32'h10000);
		cd(44, 1'b0);
		cd(45, 1'b1);
		cd(46, 1'b1);
		repeat (600) @(posedge sys_clk);
		settle;
		cd(44, 1'b1);
		cd(46, 1'b0);
		drive(32'h0);
		cd(44, 1'b0);
		cd(45, 1'b1);
		repeat (600) @(posedge sys_clk);
		settle;
		cd(45, 1'b0);
		// Edge detector on lane 17: one rising edge seen, then low.
		pg(17, lpe_pkg::OP_EDGE, 17, 0, 0, 47);
		settle;
		drive(32'h20000);
		chk(edges, 1);
		cd(47, 1'b0);
		// Packing lanes 16..31 as binary and as BCD digits.
		pg(18, lpe_pkg::OP_BIN2A, 16, 0, 0, 11);
		pg(19, lpe_pkg::OP_BCD2A, 16, 0, 0, 12);
		drive(32'h12340000);
		rda(8'h1b, 32'h1234);
		rda(8'h1c, 32'h4d2);
		// Unpacking 4660 onto lanes 48..63 as BCD, then as binary.
		pg(20, lpe_pkg::OP_A2BCD, 11, 0, 0, 48);
		settle;
		chk({16'h0, sig_out[31:16]}, 32'h4660);
		pg(20, lpe_pkg::OP_A2BIN, 11, 0, 0, 48);
		settle;
		chk({16'h0, sig_out[31:16]}, 32'h1234);
		// Pulse train on lane 18, 10 ms on and 20 ms off, then disabled.
		n0 = edges;
		pg(17, lpe_pkg::OP_PTRAIN, 18, 6, 7, 47);
		repeat (1200) @(posedge sys_clk);
		chk({31'h0, (edges - n0) >= 2}, 32'h1);
		drive(32'h0);
		cd(47, 1'b0);
		// Restart drops the set-clear bistable state, whose memory flag is clear.
		drive(32'h3000);
		drive(32'h0);
		cd(41, 1'b1);
		wr(8'h00, 32'h3);
		settle;
		cd(41, 1'b0);
		finish_test;
	end
endmodule
`default_nettype wire
